// [core/fp_pkg.sv]
`default_nettype none
package fp_pkg;
   // timing figures and clock rate
   localparam longint unsigned CLK_HZ      = 64'd200_000_000;
   localparam longint unsigned MS_PER_S    = 64'd1000;
   localparam longint unsigned CYC_PER_MS  = CLK_HZ / MS_PER_S;
   localparam longint unsigned NAME_MS     = 64'd1000;
   localparam longint unsigned RESULT_MS   = 64'd1000;
   localparam longint unsigned IDLE_S      = 64'd20;
   localparam longint unsigned DEBOUNCE_MS = 64'd10;
   localparam longint unsigned BLINK_MS    = 64'd250;
   localparam int unsigned     TMR_W       = 32;
   localparam int unsigned     DIGITS      = 5;
   localparam logic [3:0]      NUM_GROUPS  = 4'h8;
   localparam logic [2:0]      CUR_LEFT    = 3'h4;
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic mode;
      logic digit;
      logic ok;
      logic up;
      logic down;
   } key_t;
   typedef logic [DIGITS-1:0][6:0] seg_arr_t;
   typedef logic [4:0]             glyph_t;
   typedef enum logic [2:0] {
      RES_SAVED   = 3'h0,
      RES_RDONLY  = 3'h1,
      RES_PROT    = 3'h2,
      RES_RANGE   = 3'h3,
      RES_SERVO   = 3'h4,
      RES_POWERON = 3'h5,
      RES_ERROR   = 3'h6
   } store_res_t;
   typedef enum logic [2:0] {
      ST_NAME   = 3'h0,
      ST_STATUS = 3'h1,
      ST_ERROR  = 3'h2,
      ST_GROUP  = 3'h3,
      ST_EDIT   = 3'h4,
      ST_WAIT   = 3'h5,
      ST_RESULT = 3'h6
   } view_t;
   ////////////////////////////////////////////////////////////////////////
   // glyphs: 0..15 are hex digits, blank, dash and letters S T A L P R above, E reuses hex digit 14
   localparam glyph_t G_BLANK = 5'h10;
   localparam glyph_t G_DASH  = 5'h11;
   localparam glyph_t G_S     = 5'h12;
   localparam glyph_t G_T     = 5'h13;
   localparam glyph_t G_A     = 5'h14;
   localparam glyph_t G_L     = 5'h15;
   localparam glyph_t G_P     = 5'h16;
   localparam glyph_t G_R     = 5'h17;
   localparam glyph_t G_E     = 5'h0e;
   // segment order gfedcba, lit high
   function automatic logic [6:0] seg_of(input glyph_t g);
      case (g)
         5'h00: seg_of = 7'h3f;
         5'h01: seg_of = 7'h06;
         5'h02: seg_of = 7'h5b;
         5'h03: seg_of = 7'h4f;
         5'h04: seg_of = 7'h66;
         5'h05: seg_of = 7'h6d;
         5'h06: seg_of = 7'h7d;
         5'h07: seg_of = 7'h07;
         5'h08: seg_of = 7'h7f;
         5'h09: seg_of = 7'h6f;
         5'h0a: seg_of = 7'h77;
         5'h0b: seg_of = 7'h7c;
         5'h0c: seg_of = 7'h39;
         5'h0d: seg_of = 7'h5e;
         5'h0e: seg_of = 7'h79;
         5'h0f: seg_of = 7'h71;
         G_DASH: seg_of = 7'h40;
         G_S:    seg_of = 7'h6d;
         G_T:    seg_of = 7'h78;
         G_A:    seg_of = 7'h77;
         G_L:    seg_of = 7'h38;
         G_P:    seg_of = 7'h73;
         G_R:    seg_of = 7'h50;
         default: seg_of = 7'h00;
      endcase
   endfunction
endpackage
`default_nettype wire

// [core/fp_pkg_dummy_guard.sv]
`default_nettype none
`default_nettype wire

// [core/front_panel_key_display_control.sv]
`timescale 1ns/1ps
`default_nettype none
module front_panel_key_display_control #(
   parameter int unsigned DEBOUNCE_CYC = 32'(fp_pkg::DEBOUNCE_MS * fp_pkg::CYC_PER_MS),
   parameter int unsigned NAME_CYC     = 32'(fp_pkg::NAME_MS * fp_pkg::CYC_PER_MS),
   parameter int unsigned RESULT_CYC   = 32'(fp_pkg::RESULT_MS * fp_pkg::CYC_PER_MS),
   parameter int unsigned IDLE_CYC     = 32'(fp_pkg::IDLE_S * fp_pkg::CLK_HZ),
   parameter int unsigned BLINK_CYC    = 32'(fp_pkg::BLINK_MS * fp_pkg::CYC_PER_MS)
) (
   input  wire  logic                 core_clk,
   input  wire  logic                 rstn,
   input  wire  logic                 ce,
   input  wire  fp_pkg::key_t         keys,
   input  wire  logic [3:0]           power_up_view_selector,
   input  wire  logic [19:0]          status_value,
   input  wire  logic                 error_active,
   input  wire  logic [11:0]          error_code,
   input  wire  logic [19:0]          param_rd_data,
   input  wire  logic                 store_ack,
   input  wire  fp_pkg::store_res_t   store_result,
   output var   fp_pkg::seg_arr_t     disp_seg,
   output logic [3:0]                 status_sel,
   output logic [3:0]                 param_group,
   output logic [7:0]                 param_index,
   output logic                       param_wr_req,
   output logic [19:0]                param_wr_data,
   output logic                       restart_pending
);
   localparam int unsigned NK = 5;

   fp_pkg::view_t        state_ff;
   fp_pkg::view_t        nxt_state;
   fp_pkg::seg_arr_t     disp_seg_ff;
   fp_pkg::store_res_t   result_ff;
   fp_pkg::key_t         press;
   fp_pkg::glyph_t       glyph [fp_pkg::DIGITS];
   logic [NK-1:0]        raw;
   logic [NK-1:0]        stable_ff;
   logic [NK-1:0]        press_ff;
   logic [3:0]           status_sel_ff;
   logic [3:0]           group_ff;
   logic [7:0]           index_ff;
   logic [19:0]          edit_val_ff;
   logic [2:0]           cursor_ff;
   logic [fp_pkg::TMR_W-1:0] timer_ff;
   logic [fp_pkg::TMR_W-1:0] idle_ff;
   logic [fp_pkg::TMR_W-1:0] blink_cnt_ff;
   logic                 blink_ff;
   logic                 wr_req_ff;
   logic                 restart_ff;
   logic                 sel_loaded_ff;
   logic                 err_d_ff;
   logic                 err_rise;
   logic                 idle_hit;
   logic                 any_press;

   assign raw       = keys;
   assign press     = fp_pkg::key_t'(press_ff);
   assign any_press = |press_ff;
   assign err_rise  = error_active & ~err_d_ff;
   assign idle_hit  = error_active && (idle_ff == IDLE_CYC - 1) && (state_ff != fp_pkg::ST_ERROR);

   function automatic logic [19:0] bump(input logic [19:0] v, input logic [2:0] c, input logic up);
      logic [19:0] r;
      logic [3:0]  n;
      r = v;
      n = v[c*4 +: 4];
      r[c*4 +: 4] = up ? 4'(n + 4'h1) : 4'(n - 4'h1);
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // key debounce; a press must hold steady for the whole window,
   // so chatter shorter than that never reaches the menu logic
   for (genvar k = 0; k < NK; k++) begin : g_key
      logic [fp_pkg::TMR_W-1:0] db_cnt_ff;
      always_ff @(posedge core_clk or negedge rstn) begin
         if (!rstn) begin
            db_cnt_ff    <= '0;
            stable_ff[k] <= 1'b0;
            press_ff[k]  <= 1'b0;
         end else if (ce) begin
            press_ff[k] <= 1'b0;
            if (raw[k] == stable_ff[k]) begin
               db_cnt_ff <= '0;
            end else if (db_cnt_ff == DEBOUNCE_CYC - 1) begin
               db_cnt_ff    <= '0;
               stable_ff[k] <= raw[k];
               press_ff[k]  <= raw[k];
            end else begin
               db_cnt_ff <= db_cnt_ff + 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // view sequencing
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         fp_pkg::ST_NAME:   if (timer_ff == NAME_CYC - 1) nxt_state = fp_pkg::ST_STATUS;
         fp_pkg::ST_STATUS: if (press.mode) nxt_state = fp_pkg::ST_ERROR;
         fp_pkg::ST_ERROR:  if (press.mode) nxt_state = fp_pkg::ST_GROUP;
         fp_pkg::ST_GROUP: begin
            if (press.mode) nxt_state = fp_pkg::ST_STATUS;
            else if (press.ok) nxt_state = fp_pkg::ST_EDIT;
         end
         fp_pkg::ST_EDIT: begin
            if (press.mode) nxt_state = fp_pkg::ST_STATUS;
            else if (press.ok) nxt_state = fp_pkg::ST_WAIT;
         end
         fp_pkg::ST_WAIT:   if (store_ack) nxt_state = fp_pkg::ST_RESULT;
         fp_pkg::ST_RESULT: if (timer_ff == RESULT_CYC - 1) nxt_state = fp_pkg::ST_GROUP;
         default:           nxt_state = fp_pkg::ST_STATUS;
      endcase
      if (err_rise) nxt_state = fp_pkg::ST_ERROR;
      if (idle_hit) nxt_state = fp_pkg::ST_ERROR;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= fp_pkg::ST_NAME;
         timer_ff <= '0;
         err_d_ff <= 1'b0;
      end else if (ce) begin
         state_ff <= nxt_state;
         timer_ff <= (nxt_state != state_ff) ? '0 : timer_ff + 1'b1;
         err_d_ff <= error_active;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         idle_ff <= '0;
      end else if (ce) begin
         if (any_press || !error_active || state_ff == fp_pkg::ST_ERROR || idle_hit) idle_ff <= '0;
         else idle_ff <= idle_ff + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // selector is taken once, on the first enabled edge after release
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         status_sel_ff <= '0;
         sel_loaded_ff <= 1'b0;
      end else if (ce) begin
         sel_loaded_ff <= 1'b1;
         if (!sel_loaded_ff) status_sel_ff <= power_up_view_selector;
         else if (state_ff == fp_pkg::ST_STATUS && press.up) status_sel_ff <= status_sel_ff + 4'h1;
         else if (state_ff == fp_pkg::ST_STATUS && press.down) status_sel_ff <= status_sel_ff - 4'h1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         group_ff <= '0;
         index_ff <= '0;
      end else if (ce && state_ff == fp_pkg::ST_GROUP) begin
         if (press.digit) begin
            group_ff <= (group_ff == fp_pkg::NUM_GROUPS - 4'h1) ? 4'h0 : group_ff + 4'h1;
            index_ff <= '0;
         end else if (press.up) begin
            index_ff <= index_ff + 8'h01;
         end else if (press.down) begin
            index_ff <= index_ff - 8'h01;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         edit_val_ff <= '0;
         cursor_ff   <= '0;
      end else if (ce) begin
         if (state_ff == fp_pkg::ST_GROUP && press.ok && !press.mode) begin
            edit_val_ff <= param_rd_data;
            cursor_ff   <= '0;
         end else if (state_ff == fp_pkg::ST_EDIT) begin
            if (press.digit) cursor_ff <= (cursor_ff == fp_pkg::CUR_LEFT) ? 3'h0 : cursor_ff + 3'h1;
            else if (press.up) edit_val_ff <= bump(edit_val_ff, cursor_ff, 1'b1);
            else if (press.down) edit_val_ff <= bump(edit_val_ff, cursor_ff, 1'b0);
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wr_req_ff  <= 1'b0;
         result_ff  <= fp_pkg::RES_SAVED;
         restart_ff <= 1'b0;
      end else if (ce) begin
         wr_req_ff <= state_ff == fp_pkg::ST_EDIT && press.ok && !press.mode && !err_rise && !idle_hit;
         if (state_ff == fp_pkg::ST_WAIT && store_ack) result_ff <= store_result;
         if (state_ff == fp_pkg::ST_WAIT && store_ack && store_result == fp_pkg::RES_POWERON) restart_ff <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         blink_cnt_ff <= '0;
         blink_ff     <= 1'b0;
      end else if (ce) begin
         if (blink_cnt_ff == BLINK_CYC - 1) begin
            blink_cnt_ff <= '0;
            blink_ff     <= ~blink_ff;
         end else begin
            blink_cnt_ff <= blink_cnt_ff + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // display composition, digit 4 is leftmost
   always_comb begin
      for (int i = 0; i < fp_pkg::DIGITS; i++) glyph[i] = fp_pkg::G_DASH;
      case (state_ff)
         fp_pkg::ST_NAME: begin
            glyph[4] = fp_pkg::G_S;
            glyph[3] = fp_pkg::G_T;
            glyph[2] = fp_pkg::G_BLANK;
            glyph[1] = fp_pkg::G_BLANK;
            glyph[0] = {1'b0, status_sel_ff};
         end
         fp_pkg::ST_STATUS:
            for (int i = 0; i < fp_pkg::DIGITS; i++) glyph[i] = {1'b0, status_value[i*4 +: 4]};
         fp_pkg::ST_ERROR: if (error_active) begin
            glyph[4] = fp_pkg::G_A;
            glyph[3] = fp_pkg::G_L;
            for (int i = 0; i < 3; i++) glyph[i] = {1'b0, error_code[i*4 +: 4]};
         end
         fp_pkg::ST_GROUP: begin
            glyph[4] = fp_pkg::G_P;
            glyph[3] = {1'b0, group_ff};
            glyph[1] = {1'b0, index_ff[7:4]};
            glyph[0] = {1'b0, index_ff[3:0]};
         end
         fp_pkg::ST_EDIT, fp_pkg::ST_WAIT:
            for (int i = 0; i < fp_pkg::DIGITS; i++) begin
               if (state_ff == fp_pkg::ST_EDIT && blink_ff && cursor_ff == 3'(i)) glyph[i] = fp_pkg::G_BLANK;
               else glyph[i] = {1'b0, edit_val_ff[i*4 +: 4]};
            end
         fp_pkg::ST_RESULT: begin
            glyph[4] = fp_pkg::G_R;
            glyph[3] = fp_pkg::G_E;
            glyph[2] = fp_pkg::G_S;
            glyph[0] = {2'b00, result_ff};
         end
         default: ;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) disp_seg_ff <= '0;
      else if (ce) for (int i = 0; i < fp_pkg::DIGITS; i++) disp_seg_ff[i] <= fp_pkg::seg_of(glyph[i]);
   end

   assign disp_seg        = disp_seg_ff;
   assign status_sel      = status_sel_ff;
   assign param_group     = group_ff;
   assign param_index     = index_ff;
   assign param_wr_req    = wr_req_ff;
   assign param_wr_data   = edit_val_ff;
   assign restart_pending = restart_ff;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   sequence s_confirm_edit;
      ce && state_ff == fp_pkg::ST_EDIT && press.ok && !press.mode && !err_rise && !idle_hit;
   endsequence
   sequence s_written;
      wr_req_ff && state_ff == fp_pkg::ST_WAIT;
   endsequence

   property p_name_exit;
      ce && state_ff == fp_pkg::ST_NAME && timer_ff == NAME_CYC - 1 && !err_rise && !idle_hit
         |=> state_ff == fp_pkg::ST_STATUS;
   endproperty
   a_name_exit: assert property (p_name_exit) else $error("name view did not end on time");
   property p_err_force;
      ce && err_rise |=> state_ff == fp_pkg::ST_ERROR;
   endproperty
   a_err_force: assert property (p_err_force) else $error("error not forced on display");
   property p_idle_return;
      ce && idle_hit |=> state_ff == fp_pkg::ST_ERROR && idle_ff == '0;
   endproperty
   a_idle_return: assert property (p_idle_return) else $error("idle return missed");
   property p_idle_restart;
      ce && any_press |=> idle_ff == '0;
   endproperty
   a_idle_restart: assert property (p_idle_restart) else $error("press did not restart idle");
   property p_mode_cycle;
      ce && state_ff == fp_pkg::ST_ERROR && press.mode && !err_rise && !idle_hit |=> state_ff == fp_pkg::ST_GROUP;
   endproperty
   a_mode_cycle: assert property (p_mode_cycle) else $error("view did not advance");
   property p_cursor;
      ce && state_ff == fp_pkg::ST_EDIT && !press.ok && press.digit && cursor_ff != fp_pkg::CUR_LEFT
         |=> cursor_ff == $past(cursor_ff) + 3'h1;
   endproperty
   a_cursor: assert property (p_cursor) else $error("cursor did not move left");
   property p_open;
      ce && state_ff == fp_pkg::ST_GROUP && press.ok && !press.mode && !err_rise && !idle_hit
         |=> state_ff == fp_pkg::ST_EDIT && edit_val_ff == $past(param_rd_data);
   endproperty
   a_open: assert property (p_open) else $error("confirm did not open value");
   property p_commit;
      s_confirm_edit |=> s_written ##1 (!wr_req_ff || !$past(ce));
   endproperty
   a_commit: assert property (p_commit) else $error("confirm did not write value");
   property p_restart;
      ce && state_ff == fp_pkg::ST_WAIT && store_ack && store_result == fp_pkg::RES_POWERON |=> restart_pending;
   endproperty
   a_restart: assert property (p_restart) else $error("restart flag not set");
   property p_press_once;
      ce && press_ff[0] |=> !press_ff[0];
   endproperty
   a_press_once: assert property (p_press_once) else $error("press lasted more than one cycle");
endmodule // front_panel_key_display_control
`default_nettype wire

// [testbench/fp_operator.sv]
`timescale 1ns/1ps
`default_nettype none
// operator at the front panel: presses are held well past the
// debounce filter, bounces stay shorter than it
module fp_operator (
   input  wire logic         core_clk,
   output var  fp_pkg::key_t keys
);
   initial keys = '0;
   ////////////////////////////////////////////////////////////////////////
   // one clean press
   task automatic press(input int k, input int hold);
      @(posedge core_clk);
      keys[k] <= 1'b1;
      repeat (hold) @(posedge core_clk);
      keys[k] <= 1'b0;
      // release needs the filter time as well before the next press
      repeat (10) @(posedge core_clk);
      #1;
   endtask
   task automatic chatter(input int k);
      repeat (3) begin
         @(posedge core_clk);
         keys[k] <= 1'b1;
         repeat (2) @(posedge core_clk);
         keys[k] <= 1'b0;
      end
      repeat (10) @(posedge core_clk);
      #1;
   endtask
endmodule // fp_operator
`default_nettype wire

// [testbench/front_panel_key_display_control_test.sv]
`timescale 1ns/1ps
`default_nettype none
module front_panel_key_display_control_test;
   localparam int K_MODE = 4, K_DIGIT = 3, K_OK = 2, K_UP = 1, K_DOWN = 0;
   localparam int NAME_C = 20, RES_C = 20, IDLE_C = 100;
   localparam logic [6:0] HEX7 [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f, 7'h66, 7'h6d, 7'h7d, 7'h07,
                                        7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39, 7'h5e, 7'h79, 7'h71};
   localparam logic [6:0] SEG_S = 7'h6d, SEG_T = 7'h78, SEG_A = 7'h77, SEG_L = 7'h38;
   localparam logic [6:0] SEG_P = 7'h73, SEG_R = 7'h50, SEG_DASH = 7'h40;
   logic                 core_clk, rstn, ce, error_active, store_ack, param_wr_req, restart_pending;
   wire fp_pkg::key_t    keys;
   logic [3:0]           sel, status_sel, param_group;
   logic [7:0]           param_index;
   logic [11:0]          err_c;
   logic [19:0]          stat_v, rd_v, param_wr_data;
   fp_pkg::store_res_t   res, store_result;
   fp_pkg::seg_arr_t     disp_seg;
   logic [19:0]          exp_wr [$];
   int                   fail_count = 0;
   int                   cmp_count = 0;
   int                   n;

   fp_operator i_op (.core_clk (core_clk), .keys (keys));

   front_panel_key_display_control #(
      .DEBOUNCE_CYC (4), .NAME_CYC (NAME_C), .RESULT_CYC (RES_C), .IDLE_CYC (IDLE_C), .BLINK_CYC (8)
   ) i_dut (
      .core_clk (core_clk), .rstn (rstn), .ce (ce), .keys (keys),
      .power_up_view_selector (sel), .status_value (stat_v), .error_active (error_active),
      .error_code (err_c), .param_rd_data (rd_v), .store_ack (store_ack), .store_result (store_result),
      .disp_seg (disp_seg), .status_sel (status_sel), .param_group (param_group),
      .param_index (param_index), .param_wr_req (param_wr_req), .param_wr_data (param_wr_data),
      .restart_pending (restart_pending)
   );
   ////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int c);
      repeat (c) @(posedge core_clk);
      #1;
   endtask

   // bounded wait for a given leftmost glyph
   task automatic wait_lead(input logic [6:0] g, input int c);
      int i;
      i = 0;
      do begin
         tick(1);
         i++;
      end while (disp_seg[4] !== g && i < c);
   endtask

   function automatic fp_pkg::seg_arr_t hexd(input logic [19:0] v);
      for (int i = 0; i < 5; i++) hexd[i] = HEX7[v[4*i+:4]];
   endfunction

   // both blink phases must show within one and a quarter blink periods
   task automatic blink(input int d, input logic [6:0] lit);
      int on, off;
      on = 0;
      off = 0;
      repeat (20) begin
         tick(1);
         if (disp_seg[d] === 7'h00) off++;
         else if (disp_seg[d] === lit) on++;
      end
      check(on > 0 && off > 0, 1'b1);
   endtask

   task automatic save(input int r);
      logic [19:0] e;
      fp_pkg::seg_arr_t d;
      @(posedge core_clk) rd_v <= 20'($urandom);
      i_op.press(K_OK, 5);
      d = hexd(rd_v);
      check(param_wr_data, rd_v);
      check(disp_seg[4:1], d[4:1]);
      e = rd_v;
      if (r == 0) begin
         blink(0, d[0]);
         i_op.press(K_UP, 5);
         i_op.press(K_DIGIT, 5);
         i_op.press(K_UP, 5);
         // nibbles wrap on their own, no carry into the next place
         e = {rd_v[19:8], rd_v[7:4] + 4'h1, rd_v[3:0] + 4'h1};
         check(param_wr_data, e);
         d = hexd(e);
         blink(1, d[1]);
      end
      exp_wr.push_back(e);
      @(posedge core_clk) res <= fp_pkg::store_res_t'(r);
      i_op.press(K_OK, 5);
      wait_lead(SEG_R, 40);
      check(disp_seg[0], HEX7[r]);
      check(restart_pending, r >= 5);
      tick(RES_C - 12);
      check(disp_seg[4], SEG_R);
      wait_lead(SEG_P, 15);
      check(disp_seg[4], SEG_P);
   endtask
   ////////////////////////////////////////////////////////////////////////
   // store side: answers each write after a random delay
   initial forever begin
      @(posedge core_clk);
      if (param_wr_req === 1'b1) begin
         repeat ($urandom_range(6, 1)) @(posedge core_clk);
         store_ack <= 1'b1;
         store_result <= res;
         @(posedge core_clk);
         store_ack <= 1'b0;
         store_result <= fp_pkg::store_res_t'(~res);
      end
   end

   always @(posedge core_clk) begin
      if (param_wr_req === 1'b1) begin
         check(param_wr_data, exp_wr.size() > 0 ? exp_wr.pop_front() : ~param_wr_data);
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      end_sim();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'hd9c2));
      rstn = 1'b0;
      ce = 1'b1;
      error_active = 1'b0;
      store_ack = 1'b0;
      store_result = fp_pkg::RES_SAVED;
      res = fp_pkg::RES_SAVED;
      sel = 4'hf;
      stat_v = 20'($urandom);
      rd_v = 20'($urandom);
      err_c = 12'($urandom);
      tick(4);
      check(disp_seg, '0);
      check(restart_pending, 1'b0);
      @(posedge core_clk) rstn <= 1'b1;
      tick(10);
      check(status_sel, 4'hf);
      check(disp_seg, {SEG_S, SEG_T, 7'h00, 7'h00, HEX7[15]});
      // enable low freezes the name timer, so the name outlasts its enabled count
      @(posedge core_clk) ce <= 1'b0;
      repeat (24) @(posedge core_clk);
      ce <= 1'b1;
      #1;
      check(disp_seg, {SEG_S, SEG_T, 7'h00, 7'h00, HEX7[15]});
      tick(NAME_C);
      check(disp_seg, hexd(stat_v));
      i_op.chatter(K_UP);
      check(status_sel, 4'hf);
      i_op.press(K_UP, 30);
      check(status_sel, 4'h0);
      i_op.press(K_DOWN, 5);
      check(status_sel, 4'hf);
      i_op.press(K_MODE, 5);
      check(disp_seg, {5{SEG_DASH}});
      i_op.press(K_MODE, 5);
      check(disp_seg[4], SEG_P);
      for (int g = 1; g <= 8; g++) begin
         i_op.press(K_DIGIT, 5);
         check(param_group, 4'(g % 8));
      end
      i_op.press(K_DOWN, 5);
      check(param_index, 8'hff);
      check(disp_seg[1:0], {HEX7[15], HEX7[15]});
      // an answer with no write outstanding must change nothing
      @(posedge core_clk) store_ack <= 1'b1;
      store_result <= fp_pkg::RES_POWERON;
      @(posedge core_clk) store_ack <= 1'b0;
      tick(2);
      check(restart_pending, 1'b0);
      for (int r = 0; r < 7; r++) save(r);
      check(exp_wr.size(), 0);
      @(posedge core_clk) error_active <= 1'b1;
      wait_lead(SEG_A, 5);
      check(disp_seg, {SEG_A, SEG_L, HEX7[err_c[11:8]], HEX7[err_c[7:4]], HEX7[err_c[3:0]]});
      i_op.press(K_MODE, 5);
      check(disp_seg[4], SEG_P);
      i_op.press(K_UP, 5);
      tick(50);
      i_op.press(K_UP, 5);
      n = 0;
      repeat (60) begin
         tick(1);
         if (disp_seg[4] === SEG_A) n++;
      end
      check(n, 0);
      wait_lead(SEG_A, 60);
      check(disp_seg[4], SEG_A);
      end_sim();
   end
endmodule // front_panel_key_display_control_test
`default_nettype wire
